// >>> logic/tw_defs.svh
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

`define TW_CLK_PERIOD_NS              4
`define TW_POWER_UP_COMMAND_DELAY_US  100
`define TW_POWER_UP_COMMAND_DELAY_CYC ((`TW_POWER_UP_COMMAND_DELAY_US * 1000 + `TW_CLK_PERIOD_NS - 1) / `TW_CLK_PERIOD_NS)
`define TW_SCL_QUARTER_NS             625
`define TW_SCL_QUARTER_CYC            ((`TW_SCL_QUARTER_NS + `TW_CLK_PERIOD_NS - 1) / `TW_CLK_PERIOD_NS)
`define TW_DATA_W                     8
`define TW_ACK_BIT_IDX                4'h8
`define TW_RECOVER_LAST_IDX           4'h8
`define TW_FIFO_DEPTH                 32

`endif

// >>> logic/tw_pkg.sv
package tw_pkg;

    typedef enum logic [2:0] {
        ST_POWERUP = 3'h0,
        ST_IDLE    = 3'h1,
        ST_START   = 3'h2,
        ST_BYTE    = 3'h3,
        ST_ENDB    = 3'h4,
        ST_STOP    = 3'h5,
        ST_RECOVER = 3'h6
    } tw_state_t;

    typedef enum logic [2:0] {
        OP_START   = 3'h0,
        OP_WRITE   = 3'h1,
        OP_READ    = 3'h2,
        OP_STOP    = 3'h3,
        OP_RECOVER = 3'h4
    } tw_op_t;

    typedef struct packed {
        tw_state_t  st;
        logic [2:0] op;
        logic [31:0] pup_cnt;
        logic [7:0] qcnt;
        logic [1:0] q;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] rd;
        logic       nack;
        logic       ackbit;
        logic       scl_low;
        logic       sda_low;
        logic       scl_m;
        logic       scl_s;
        logic       sda_m;
        logic       sda_s;
        logic       idle;
        logic       ack;
        logic       err;
        logic       done;
        logic       push;
    } tw_master_st_t;

endpackage : tw_pkg

// >>> logic/tw_stream_if.sv
interface tw_stream_if #(
    parameter int W = 8
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : tw_stream_if

// >>> logic/tw_fifo.sv
module tw_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // Streams
    tw_stream_if.snk  in_s,
    tw_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    ov;
        logic [W-1:0]            od;
    } tw_fifo_st_t;

    tw_fifo_st_t s_r;
    tw_fifo_st_t s_nxt;
    logic        push;
    logic        pop;

    assign in_s.ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_s.valid = s_r.ov;
    assign out_s.data  = s_r.od;

    always_comb begin
        s_nxt = s_r;
        push  = in_s.valid && in_s.ready;
        pop   = (s_r.cnt != '0) && (!s_r.ov || out_s.ready);
        if (push) begin
            s_nxt.mem[s_r.wp] = in_s.data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.od = s_r.mem[s_r.rp];
            s_nxt.rp = s_r.rp + 1'b1;
            s_nxt.ov = 1'b1;
        end else if (out_s.ready) begin
            s_nxt.ov = 1'b0;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : tw_fifo

// >>> logic/tw_master.sv
// Operation
// [R1] Device ignores the bus until its supply passes its reset threshold.
// [R2] Master waits the power-up delay after reset before the first command.
// [R3] Receiver samples data on rising clock; data changes after falling clock.
// [R4] Bytes travel most significant bit first, one bit per clock.
// [R5] Each byte takes nine clocks: eight data bits and one answer bit.
// [R6] Master clocks each byte and its answer bit without pauses.
// [R7] Data line changes only while clock is low, stable while high.
// [R8] Device sees a Start as data falling while clock is high.
// [R9] Every command begins with a Start; device waits for one.
// [R10] Device sees a Stop as data rising while clock is high.
// [R11] A repeated Start may replace a Stop and begins a new operation.
// [R12] Any number of bytes may pass between Start and Stop.
// [R13] Bus is idle only when clock and data are both high.
// [R14] Transmitter releases data after eighth clock; receiver holds low during ninth.
// [R15] Master ends a read by leaving data high in the ninth clock.
// [R16] Receiver releases data at the end of the ninth clock.
// [R17] Device drives data only open-drain, pull-up gives the high level.
// [R18] Device is slave only and never drives the clock.
// [R19] Device returns to standby on Stop, or after its write cycle.
// [R20] Recovery toggles clock until data is released, at most nine, then Start; the master then returns to idle and sends the Start only on OP_START.
// [R21] Device leaves data released unless sending a bit or an acknowledge.
`include "tw_defs.svh"

module tw_master
    import tw_pkg::*;
#(
    parameter int unsigned PUP_CYCLES = `TW_POWER_UP_COMMAND_DELAY_CYC
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Command port
    input  wire logic       cmd_valid_i,
    output logic            cmd_ready_o,
    input  wire tw_op_t     cmd_op_i,
    input  wire logic [7:0] cmd_data_i,
    input  wire logic       cmd_nack_i,
    // Status
    output logic            done_o,
    output logic            ack_o,
    output logic            err_o,
    output logic            busy_o,
    output logic            bus_idle_o,
    // Read data stream
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    output logic [7:0]      rx_data_o,
    // Serial clock pin
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    // Serial data pin
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o
);
    localparam logic [7:0] QCYC = 8'(`TW_SCL_QUARTER_CYC);

    tw_master_st_t s_r;
    tw_master_st_t s_nxt;
    logic          step;
    logic          accept;

    tw_stream_if #(.W(`TW_DATA_W)) rx_in ();
    tw_stream_if #(.W(`TW_DATA_W)) rx_out ();

    tw_fifo #(
        .W     (`TW_DATA_W),
        .DEPTH (`TW_FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .in_s    (rx_in.snk),
        .out_s   (rx_out.src)
    );

    assign rx_in.valid  = s_r.push;
    assign rx_in.data   = s_r.rd;
    assign rx_out.ready = rx_ready_i;
    assign rx_valid_o   = rx_out.valid;
    assign rx_data_o    = rx_out.data;

    // A read is only taken when the buffer has room for its byte
    assign cmd_ready_o = (s_r.st == ST_IDLE)
                       && !(cmd_op_i == OP_READ && !rx_in.ready);
    assign accept      = cmd_valid_i && cmd_ready_o;

    // Both pins are open-drain: low when enabled, released otherwise
    assign scl_o      = 1'b0;
    assign scl_oe_o   = s_r.scl_low;
    assign sda_o      = 1'b0;
    assign sda_oe_o   = s_r.sda_low;
    assign done_o     = s_r.done;
    assign ack_o      = s_r.ack;
    assign err_o      = s_r.err;
    assign busy_o     = (s_r.st != ST_IDLE);
    assign bus_idle_o = s_r.idle;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.done  = 1'b0;
        s_nxt.push  = 1'b0;
        s_nxt.scl_m = scl_i;
        s_nxt.scl_s = s_r.scl_m;
        s_nxt.sda_m = sda_i;
        s_nxt.sda_s = s_r.sda_m;
        s_nxt.idle  = s_r.scl_s && s_r.sda_s; // [R13]
        // Quarter-period timer; the high phase waits while the clock is held low
        step = 1'b0;
        if (s_r.st != ST_IDLE && s_r.st != ST_POWERUP) begin
            if (s_r.qcnt == QCYC - 8'h01) begin
                s_nxt.qcnt = 8'h00;
                step       = !(s_r.q == 2'h2 && !s_r.scl_s);
            end else begin
                s_nxt.qcnt = s_r.qcnt + 8'h01;
            end
        end
        if (step) begin
            s_nxt.q = s_r.q + 2'h1; // [R6]
        end
        unique case (s_r.st)
            ST_POWERUP: begin
                if (s_r.pup_cnt == PUP_CYCLES - 1) begin
                    s_nxt.st = ST_IDLE; // [R2]
                end else begin
                    s_nxt.pup_cnt = s_r.pup_cnt + 32'h1;
                end
            end
            ST_IDLE: begin
                if (accept) begin
                    s_nxt.op   = cmd_op_i;
                    s_nxt.sh   = cmd_data_i;
                    s_nxt.nack = cmd_nack_i;
                    s_nxt.bitn = 4'h0;
                    s_nxt.q    = 2'h0;
                    s_nxt.qcnt = 8'h00;
                    unique case (cmd_op_i)
                        OP_START:   s_nxt.st = ST_START; // [R9] [R11]
                        OP_WRITE:   s_nxt.st = ST_BYTE; // [R12]
                        OP_READ:    s_nxt.st = ST_BYTE; // [R12]
                        OP_STOP:    s_nxt.st = ST_STOP;
                        OP_RECOVER: s_nxt.st = ST_RECOVER;
                        default: begin
                            s_nxt.err  = 1'b1;
                            s_nxt.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_START: begin
                if (step) begin
                    unique case (s_r.q)
                        2'h0: s_nxt.sda_low = 1'b0;
                        2'h1: s_nxt.scl_low = 1'b0;
                        2'h2: s_nxt.sda_low = 1'b1; // [R9]
                        2'h3: begin
                            s_nxt.scl_low = 1'b1;
                            s_nxt.st      = ST_IDLE;
                            s_nxt.err     = 1'b0;
                            s_nxt.done    = 1'b1;
                        end
                    endcase
                end
            end
            ST_BYTE: begin
                if (step) begin
                    unique case (s_r.q)
                        2'h0: begin
                            s_nxt.scl_low = 1'b1;
                            // Data changes only in the low phase
                            if (s_r.bitn != `TW_ACK_BIT_IDX) begin // [R7] [R3]
                                s_nxt.sda_low = (s_r.op == OP_WRITE) && !s_r.sh[7]; // [R4]
                            end else if (s_r.op == OP_WRITE) begin
                                s_nxt.sda_low = 1'b0; // [R14]
                            end else begin
                                s_nxt.sda_low = !s_r.nack; // [R14] [R15]
                            end
                        end
                        2'h1: s_nxt.scl_low = 1'b0;
                        2'h2: begin
                            if (s_r.bitn != `TW_ACK_BIT_IDX) begin
                                s_nxt.rd = {s_r.rd[6:0], s_r.sda_s}; // [R3] [R4]
                            end else begin
                                s_nxt.ackbit = s_r.sda_s;
                            end
                        end
                        2'h3: begin
                            s_nxt.scl_low = 1'b1;
                            if (s_r.bitn == `TW_ACK_BIT_IDX) begin
                                s_nxt.st = ST_ENDB; // [R5]
                            end else begin
                                s_nxt.bitn = s_r.bitn + 4'h1;
                                s_nxt.sh   = {s_r.sh[6:0], 1'b0};
                            end
                        end
                    endcase
                end
            end
            ST_ENDB: begin
                if (step) begin
                    s_nxt.sda_low = 1'b0; // [R16]
                    s_nxt.ack     = !s_r.ackbit;
                    s_nxt.err     = 1'b0;
                    s_nxt.push    = (s_r.op == OP_READ);
                    s_nxt.done    = 1'b1;
                    s_nxt.st      = ST_IDLE;
                end
            end
            ST_STOP: begin
                if (step) begin
                    unique case (s_r.q)
                        2'h0: begin
                            s_nxt.scl_low = 1'b1;
                            s_nxt.sda_low = 1'b1;
                        end
                        2'h1: s_nxt.scl_low = 1'b0;
                        2'h2: s_nxt.scl_low = 1'b0;
                        2'h3: begin
                            s_nxt.sda_low = 1'b0;
                            s_nxt.st      = ST_IDLE;
                            s_nxt.err     = 1'b0;
                            s_nxt.done    = 1'b1;
                        end
                    endcase
                end
            end
            ST_RECOVER: begin
                if (step) begin
                    unique case (s_r.q)
                        2'h0: begin
                            s_nxt.scl_low = 1'b1;
                            s_nxt.sda_low = 1'b0;
                        end
                        2'h1: s_nxt.scl_low = 1'b0;
                        2'h2: begin
                            if (s_r.sda_s) begin
                                s_nxt.st   = ST_IDLE; // [R20]
                                s_nxt.err  = 1'b0;
                                s_nxt.done = 1'b1;
                            end
                        end
                        2'h3: begin
                            s_nxt.scl_low = 1'b1;
                            if (s_r.bitn == `TW_RECOVER_LAST_IDX) begin
                                s_nxt.st   = ST_IDLE; // [R20]
                                s_nxt.err  = 1'b1;
                                s_nxt.done = 1'b1;
                            end else begin
                                s_nxt.bitn = s_r.bitn + 4'h1;
                            end
                        end
                    endcase
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : tw_master

// >>> verification/tw_master_properties.sv
module tw_master_properties
    import tw_pkg::*;
#(
    parameter int unsigned PUP_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Status
    input wire logic cmd_ready_o,
    input wire logic done_o,
    input wire logic bus_idle_o,
    // Pins
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] since_rst_r;

    // Cycles since reset release, saturating
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            since_rst_r <= 32'h0;
        end else if (since_rst_r != 32'hFFFFFFFF) begin
            since_rst_r <= since_rst_r + 32'h1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    property p_pup_wait;
        cmd_ready_o |-> since_rst_r >= PUP_CYCLES;
    endproperty
    a_pup_wait: assert property (p_pup_wait)
        else $error("ready before power-up delay");
    property p_rst_quiet;
        disable iff (1'b0) reset_i |-> !scl_oe_o && !sda_oe_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("bus driven in reset");
    property p_open_drain;
        !scl_o && !sda_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("pin driven high");
    property p_scl_high;
        $fell(scl_oe_o) |-> ##[1:330] ($rose(scl_oe_o) || done_o);
    endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("clock high phase too long");
    property p_scl_low;
        $rose(scl_oe_o) |-> ##[0:330] ($fell(scl_oe_o) || done_o);
    endproperty
    a_scl_low: assert property (p_scl_low)
        else $error("clock low phase too long");
    property p_data_stable;
        $fell(scl_oe_o) |-> $stable(sda_oe_o)[*8];
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data moved with clock high");
    property p_start;
        $rose(sda_oe_o) && !scl_oe_o |-> ##[150:170] $rose(scl_oe_o);
    endproperty
    a_start: assert property (p_start)
        else $error("start not closed by clock low");
    property p_stop;
        $fell(sda_oe_o) && !scl_oe_o |-> ##[0:2] done_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop not ending command");
    property p_idle;
        (!scl_i)[*5] |-> !bus_idle_o;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle with clock low");
endmodule : tw_master_properties

bind tw_master tw_master_properties #(.PUP_CYCLES(PUP_CYCLES)) u_props (.*);

// >>> verification/tw_eeprom_model.sv
module tw_eeprom_model (
    // Bus pins; no clock output, the device only listens
    input  wire logic       por_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_o,
    // Scenario controls
    input  wire logic       tx_mode_i,
    input  wire logic       ack_en_i,
    input  wire logic [7:0] tx_byte_i,
    // Received bytes
    output logic [7:0]      rx_byte_o,
    output logic            rx_stb_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic active = 1'b0;
    int   bitn   = 0;

    initial begin
        sda_oe_o = 1'b0;
        rx_stb_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    // Start wakes the device, not while in power-on reset
    always @(negedge sda_i) begin
        if (scl_i === 1'b1 && por_i === 1'b0) begin
            active = 1'b1;
            bitn = 0;
        end
    end
    // Stop or reset: standby with the line released
    always @(posedge sda_i or posedge por_i) begin
        if (scl_i === 1'b1 || por_i === 1'b1) begin
            active = 1'b0;
            sda_oe_o = 1'b0;
        end
    end
    // Sample on rising clock, most significant bit first
    always @(posedge scl_i) begin
        if (active && bitn < 8) begin
            rx_byte_o = {rx_byte_o[6:0], sda_i};
        end else if (active && tx_mode_i && sda_i === 1'b1) begin
            active = 1'b0;
        end
        bitn++;
    end
    // Change the line only after falling clock
    always @(negedge scl_i) begin
        if (active) begin
            if (bitn >= 9) bitn = 0;
            if (bitn == 8) begin
                sda_oe_o = !tx_mode_i && ack_en_i;
            end else begin
                sda_oe_o = tx_mode_i && !tx_byte_i[7 - bitn];
            end
            if (bitn == 8 && !tx_mode_i) begin
                rx_stb_o = 1'b1;
                rx_stb_o <= #8 1'b0;
            end
        end
    end
endmodule : tw_eeprom_model

// >>> verification/two_wire_eeprom_bus_frontend_tb_top.sv
module two_wire_eeprom_bus_frontend_tb_top import tw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PUP_CYCLES = 20;
    logic       clk_i       = 1'b0;
    logic       reset_i;
    logic       cmd_valid_i = 1'b0;
    tw_op_t     cmd_op_i    = OP_START;
    logic [7:0] cmd_data_i  = 8'h00;
    logic       cmd_nack_i  = 1'b0;
    logic       rx_ready_i  = 1'b0;
    logic       cmd_ready_o, done_o, ack_o, err_o, busy_o, bus_idle_o, rx_valid_o;
    logic       scl_o, scl_oe_o, sda_o, sda_oe_o, dev_oe, dev_stb, scl_i, sda_i;
    logic [7:0] rx_data_o, dev_rx;
    logic [7:0] tx_byte     = 8'h00;
    logic       tx_mode     = 1'b0;
    logic       ack_en      = 1'b1;
    integer     seed        = 32'hc174;
    int         err_total   = 0;
    int         checked     = 0;
    logic [1:0] exp_st[$];
    logic [7:0] exp_rx[$];
    logic [7:0] exp_wr[$];

    // Pull-ups on both wires; only the master pulls the clock
    assign scl_i = !scl_oe_o;
    assign sda_i = !(sda_oe_o || dev_oe);
    always #2 clk_i = ~clk_i;

    tw_master #(.PUP_CYCLES(PUP_CYCLES)) uut (.*);
    tw_eeprom_model u_dev (
        .por_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(dev_oe), .tx_mode_i(tx_mode),
        .ack_en_i(ack_en), .tx_byte_i(tx_byte), .rx_byte_o(dev_rx), .rx_stb_o(dev_stb)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic run(input tw_op_t op, input logic [7:0] d, input logic nk,
                       input logic [1:0] st);
        int n;
        exp_st.push_back(st);
        @(negedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        cmd_data_i <= d;
        cmd_nack_i <= nk;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 9000) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        cmd_valid_i <= 1'b0;
        while (busy_o !== 1'b0 && n < 9000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 9000) err_total++;
    endtask : run

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    always @(negedge clk_i) begin
        if (done_o === 1'b1) check({6'h00, ack_o, err_o}, {6'h00, exp_st.pop_front()});
        rx_ready_i <= 1'($random(seed));
    end
    always @(posedge clk_i) begin
        if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) check(rx_data_o, exp_rx.pop_front());
    end
    always @(posedge dev_stb) check(dev_rx, exp_wr.pop_front());

    initial begin
        #300000;
        err_total++;
        stop_test();
    end

    initial begin
        logic [7:0] d;
        reset_i = 1'b1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        reset_i <= 1'b0;
        repeat (PUP_CYCLES - 2) @(negedge clk_i);
        check({7'h00, cmd_ready_o}, 8'h00);
        repeat (3) @(negedge clk_i);
        check({7'h00, cmd_ready_o}, 8'h01);
        $display("test power-up ended");
        run(OP_START, 8'h00, 1'b0, 2'b00);
        for (int i = 0; i < 2; i++) begin
            ack_en = (i == 0);
            d = 8'($random(seed));
            exp_wr.push_back(d);
            run(OP_WRITE, d, 1'b0, {ack_en, 1'b0});
        end
        $display("test write ended");
        tx_byte = 8'($random(seed));
        tx_mode = 1'b1;
        run(OP_START, 8'h00, 1'b0, 2'b00);
        for (int i = 0; i < 2; i++) begin
            exp_rx.push_back(tx_byte);
            run(OP_READ, 8'h00, i[0], {~i[0], 1'b0});
        end
        run(OP_STOP, 8'h00, 1'b0, 2'b00);
        $display("test read ended");
        tx_byte = 8'h3C;
        run(OP_START, 8'h00, 1'b0, 2'b00);
        exp_rx.push_back(8'h3C);
        run(OP_READ, 8'h00, 1'b0, 2'b10);
        run(OP_RECOVER, 8'h00, 1'b0, 2'b10);
        tx_mode = 1'b0;
        run(OP_START, 8'h00, 1'b0, 2'b10);
        run(OP_STOP, 8'h00, 1'b0, 2'b10);
        repeat (8) @(negedge clk_i);
        check({7'h00, bus_idle_o}, 8'h01);
        $display("test recover ended");
        run(tw_op_t'(3'h5), 8'h00, 1'b0, 2'b11);
        run(OP_START, 8'h00, 1'b0, 2'b10);
        run(OP_STOP, 8'h00, 1'b0, 2'b10);
        $display("test illegal ended");
        repeat (20) @(negedge clk_i);
        check(8'(exp_st.size() + exp_rx.size() + exp_wr.size()), 8'h00);
        stop_test();
    end
endmodule : two_wire_eeprom_bus_frontend_tb_top
